/* File: verilog/ppfm_pkg.sv */
// Package for the port pin function multiplexer: modes, fields, carriers
package ppfm_pkg;
   // =============================================
   // Pin positions
   localparam int A_RST_BIT   = 3;
   localparam int A_MOSI_BIT  = 5;
   localparam int A_MISO_BIT  = 6;
   localparam int A_SCK_BIT   = 7;
   localparam int B_RXD_BIT   = 0;
   localparam int B_OSC_BIT   = 2;
   localparam int B_T0_BIT    = 4;
   localparam int B_T1_BIT    = 5;
   localparam int PORT_W      = 8;
   // =============================================
   // Reset values
   localparam logic [7:0]  LATCH_RST = 8'hFF;
   localparam logic [15:0] MODE_RST  = 16'h0000;
   // =============================================
   // Drive modes, two bits per pin
   typedef enum logic [1:0] {
      PPFM_QUASI = 2'h0,
      PPFM_INPUT = 2'h1,
      PPFM_PUSH  = 2'h2,
      PPFM_OPEN  = 2'h3
   } ppfm_mode_t;
   // =============================================
   // Alternate function drive toward one pin
   typedef struct packed {
      logic own;
      logic val;
      logic oe;
   } ppfm_alt_t;
   // Pad signals of one pin
   typedef struct packed {
      logic o;
      logic oe;
   } ppfm_pad_t;
endpackage

/* File: verilog/ppfm_port_pin_function_mux.sv */
// Pin function multiplexer and port drive mode logic for two 8-bit ports
`timescale 1ns/1ps
// Behaviour
// - Port A bit 3 is port bit unless reset fuse or debug set; fuse makes it active-low reset in.
// - SPI data out pin drives in master, senses in slave.
// - SPI clock pin drives in master, senses in slave.
// - Port B bit 2 feeds oscillator on external clock, else free port bit unless debug is on.
// - Debug on with RC clock makes port B bit 2 debug data line.
// - Debug on takes debug serial clock from port A bit 3.
// - Each bit has four drive modes; quasi mode acts like classic port.
// - Input mode leaves pad undriven, only sensing.
// - Push-pull drives both levels; open-drain drives only low.
// - All eight port A pins can raise general pin interrupts.
// - Port B bit 4 is timer zero count input or PWM output.
// - Port B bit 0 routes to UART receive input.
// - SPI data in pin senses in master, drives in slave.
// - Port B bit 5 is timer one count input or PWM output.
module ppfm_port_pin_function_mux #(
   parameter int QUASI_KICK = 2
) (
   input  wire logic        i_ref_clk,
   input  wire logic        i_arst_n,
   input  wire logic        i_reset_fuse,
   input  wire logic        i_on_chip_debug,
   input  wire logic        i_rc_osc_sel,
   input  wire logic        i_spi_en,
   input  wire logic        i_spi_master,
   input  wire logic        i_spi_mosi,
   input  wire logic        i_spi_miso,
   input  wire logic        i_spi_sck,
   input  wire logic        i_t0_pwm_en,
   input  wire logic        i_t0_pwm,
   input  wire logic        i_t1_pwm_en,
   input  wire logic        i_t1_pwm,
   input  wire logic        i_dbg_data_oe,
   input  wire logic        i_dbg_data_o,
   input  wire logic        i_latch_wr_a,
   input  wire logic [7:0]  i_latch_a,
   input  wire logic        i_latch_wr_b,
   input  wire logic [7:0]  i_latch_b,
   input  wire logic [15:0] i_mode_a,
   input  wire logic [15:0] i_mode_b,
   input  wire logic [7:0]  i_gpi_en,
   input  wire logic [7:0]  i_gpi_level,
   input  wire logic [7:0]  i_gpi_pol,
   input  wire logic [7:0]  i_pad_a_i,
   input  wire logic [7:0]  i_pad_b_i,
   output logic      [7:0]  o_pad_a_o,
   output logic      [7:0]  o_pad_a_oe,
   output logic      [7:0]  o_pad_b_o,
   output logic      [7:0]  o_pad_b_oe,
   output logic      [7:0]  o_port_a_in,
   output logic      [7:0]  o_port_b_in,
   output logic             o_ext_reset_n,
   output logic             o_debug_serial_clock,
   output logic             o_debug_serial_data,
   output logic             o_oscillator_input,
   output logic             o_spi_mosi_in,
   output logic             o_spi_miso_in,
   output logic             o_spi_sck_in,
   output logic             o_timer_zero_pin,
   output logic             o_timer_one_pin,
   output logic             o_uart_rxd,
   output logic             o_general_pin_interrupt
);
   // =============================================
   // Reset synchroniser
   logic rst_s1_q;
   logic rst_n_q;
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // =============================================
   // Port latches and quasi strong-pull kick
   logic [7:0] latch_a_q;
   logic [7:0] latch_b_q;
   logic [7:0] kick_a_q;
   logic [7:0] kick_b_q;
   localparam int KW = $clog2(QUASI_KICK + 1);
   logic [KW-1:0] kick_cnt_a_q;
   logic [KW-1:0] kick_cnt_b_q;

   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         latch_a_q <= ppfm_pkg::LATCH_RST;
         latch_b_q <= ppfm_pkg::LATCH_RST;
      end else begin
         if (i_latch_wr_a) begin
            latch_a_q <= i_latch_a;
         end
         if (i_latch_wr_b) begin
            latch_b_q <= i_latch_b;
         end
      end
   end

   // quasi low-to-high kick
   // A latch rising from 0 to 1 gets a short strong pull-up, then only the weak pull holds it
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         kick_a_q     <= 8'h00;
         kick_b_q     <= 8'h00;
         kick_cnt_a_q <= '0;
         kick_cnt_b_q <= '0;
      end else begin
         if (i_latch_wr_a && ((i_latch_a & ~latch_a_q) != 8'h00)) begin
            kick_a_q     <= i_latch_a & ~latch_a_q;
            kick_cnt_a_q <= KW'(QUASI_KICK);
         end else if (kick_cnt_a_q != '0) begin
            kick_cnt_a_q <= kick_cnt_a_q - 1'b1;
         end else begin
            kick_a_q <= 8'h00;
         end
         if (i_latch_wr_b && ((i_latch_b & ~latch_b_q) != 8'h00)) begin
            kick_b_q     <= i_latch_b & ~latch_b_q;
            kick_cnt_b_q <= KW'(QUASI_KICK);
         end else if (kick_cnt_b_q != '0) begin
            kick_cnt_b_q <= kick_cnt_b_q - 1'b1;
         end else begin
            kick_b_q <= 8'h00;
         end
      end
   end

   // =============================================
   // Drive mode decode, shared by both ports
   function automatic ppfm_pkg::ppfm_pad_t drive(input logic [1:0] mode, input logic val,
                                                  input logic kick);
      ppfm_pkg::ppfm_pad_t p;
      p.o  = val;
      p.oe = 1'b0;
      unique case (ppfm_pkg::ppfm_mode_t'(mode))
         // quasi drives low, high only during kick
         ppfm_pkg::PPFM_QUASI: p.oe = ~val | kick;
         ppfm_pkg::PPFM_INPUT: p.oe = 1'b0;
         ppfm_pkg::PPFM_PUSH:  p.oe = 1'b1;
         ppfm_pkg::PPFM_OPEN:  p.oe = ~val;
      endcase
      return p;
   endfunction

   // =============================================
   // Alternate function ownership
   ppfm_pkg::ppfm_alt_t alt_a [8];
   ppfm_pkg::ppfm_alt_t alt_b [8];
   logic dbg_data_on;
   logic osc_on;
   logic rst_pin_on;
   assign dbg_data_on = i_on_chip_debug & i_rc_osc_sel;
   assign osc_on      = ~i_rc_osc_sel;
   assign rst_pin_on  = i_reset_fuse | i_on_chip_debug;

   always_comb begin
      for (int k = 0; k < ppfm_pkg::PORT_W; k++) begin
         alt_a[k] = '0;
         alt_b[k] = '0;
      end
      alt_a[ppfm_pkg::A_RST_BIT] = '{own: rst_pin_on, val: 1'b0, oe: 1'b0};
      alt_a[ppfm_pkg::A_MOSI_BIT] = '{own: i_spi_en, val: i_spi_mosi, oe: i_spi_master};
      alt_a[ppfm_pkg::A_MISO_BIT] = '{own: i_spi_en, val: i_spi_miso, oe: ~i_spi_master};
      alt_a[ppfm_pkg::A_SCK_BIT] = '{own: i_spi_en, val: i_spi_sck, oe: i_spi_master};
      if (dbg_data_on) begin
         alt_b[ppfm_pkg::B_OSC_BIT] = '{own: 1'b1, val: i_dbg_data_o, oe: i_dbg_data_oe};
      end else begin
         alt_b[ppfm_pkg::B_OSC_BIT] = '{own: osc_on, val: 1'b0, oe: 1'b0};
      end
      alt_b[ppfm_pkg::B_T0_BIT] = '{own: i_t0_pwm_en, val: i_t0_pwm, oe: 1'b1};
      alt_b[ppfm_pkg::B_T1_BIT] = '{own: i_t1_pwm_en, val: i_t1_pwm, oe: 1'b1};
   end

   // =============================================
   // Pad drive, registered
   // alternate function replaces latch
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_pad_a_o  <= 8'h00;
         o_pad_a_oe <= 8'h00;
         o_pad_b_o  <= 8'h00;
         o_pad_b_oe <= 8'h00;
      end else begin
         for (int k = 0; k < ppfm_pkg::PORT_W; k++) begin
            if (alt_a[k].own) begin
               o_pad_a_o[k]  <= alt_a[k].val;
               o_pad_a_oe[k] <= alt_a[k].oe;
            end else begin
               {o_pad_a_o[k], o_pad_a_oe[k]} <= drive(i_mode_a[2*k +: 2], latch_a_q[k], kick_a_q[k]);
            end
            if (alt_b[k].own) begin
               o_pad_b_o[k]  <= alt_b[k].val;
               o_pad_b_oe[k] <= alt_b[k].oe;
            end else begin
               {o_pad_b_o[k], o_pad_b_oe[k]} <= drive(i_mode_b[2*k +: 2], latch_b_q[k], kick_b_q[k]);
            end
         end
      end
   end

   // =============================================
   // Inputs toward the core and peripherals
   // Pin levels stay readable even while a function owns the pad
   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_port_a_in          <= 8'hFF;
         o_port_b_in          <= 8'hFF;
         o_ext_reset_n        <= 1'b1;
         o_debug_serial_clock <= 1'b0;
         o_debug_serial_data  <= 1'b1;
         o_oscillator_input   <= 1'b0;
         o_spi_mosi_in        <= 1'b1;
         o_spi_miso_in        <= 1'b1;
         o_spi_sck_in         <= 1'b0;
         o_timer_zero_pin     <= 1'b1;
         o_timer_one_pin      <= 1'b1;
         o_uart_rxd           <= 1'b1;
      end else begin
         o_port_a_in <= i_pad_a_i;
         o_port_b_in <= i_pad_b_i;
         o_ext_reset_n <= i_reset_fuse ? i_pad_a_i[ppfm_pkg::A_RST_BIT] : 1'b1;
         o_debug_serial_clock <= i_on_chip_debug & i_pad_a_i[ppfm_pkg::A_RST_BIT];
         o_debug_serial_data <= dbg_data_on ? i_pad_b_i[ppfm_pkg::B_OSC_BIT] : 1'b1;
         o_oscillator_input <= osc_on & i_pad_b_i[ppfm_pkg::B_OSC_BIT];
         o_spi_mosi_in <= i_pad_a_i[ppfm_pkg::A_MOSI_BIT];
         o_spi_miso_in <= i_pad_a_i[ppfm_pkg::A_MISO_BIT];
         o_spi_sck_in <= i_pad_a_i[ppfm_pkg::A_SCK_BIT];
         o_timer_zero_pin <= i_pad_b_i[ppfm_pkg::B_T0_BIT];
         o_timer_one_pin <= i_pad_b_i[ppfm_pkg::B_T1_BIT];
         o_uart_rxd <= i_pad_b_i[ppfm_pkg::B_RXD_BIT];
      end
   end

   // =============================================
   // General pin interrupt, level or edge per bit
   // Edge history comes from the registered port copy, so an edge is flagged as fast as a level
   logic [7:0] gpi_hit;
   always_comb begin
      for (int k = 0; k < ppfm_pkg::PORT_W; k++) begin
         if (i_gpi_level[k]) begin
            gpi_hit[k] = i_pad_a_i[k] ~^ i_gpi_pol[k];
         end else begin
            gpi_hit[k] = (i_pad_a_i[k] ~^ i_gpi_pol[k]) & (o_port_a_in[k] ^ i_gpi_pol[k]);
         end
      end
   end

   always_ff @(posedge i_ref_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         o_general_pin_interrupt <= 1'b0;
      end else begin
         o_general_pin_interrupt <= |(gpi_hit & i_gpi_en);
      end
   end

   // =============================================
   // Checks
   // input mode undriven
   input_tristate_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (!i_spi_en && !rst_pin_on && i_mode_a[1:0] == 2'h1) |=> !o_pad_a_oe[0])
      else $error("input mode pin driven");
   open_drain_low_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (!i_spi_en && i_mode_a[5:4] == 2'h3) |=> !(o_pad_a_oe[2] && o_pad_a_o[2]))
      else $error("open drain drove high");
   push_pull_on_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (i_mode_b[3:2] == 2'h2) |=> (o_pad_b_oe[1] && o_pad_b_o[1] == $past(latch_b_q[1])))
      else $error("push pull not driving latch");
   fuse_reset_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      i_reset_fuse |=> (!o_pad_a_oe[3] && o_ext_reset_n == $past(i_pad_a_i[3])))
      else $error("reset pin misrouted");
   spi_out_role_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      i_spi_en |=> (o_pad_a_oe[5] == $past(i_spi_master) && o_pad_a_oe[6] == !$past(i_spi_master)))
      else $error("spi data direction wrong");
   spi_clk_role_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (i_spi_en && i_spi_master) |=> (o_pad_a_oe[7] && o_pad_a_o[7] == $past(i_spi_sck)))
      else $error("spi clock not driven");
   debug_data_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (i_on_chip_debug && i_rc_osc_sel) |=> (o_pad_b_oe[2] == $past(i_dbg_data_oe)))
      else $error("debug data enable wrong");
   osc_pin_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      !i_rc_osc_sel |=> (!o_pad_b_oe[2] && o_oscillator_input == $past(i_pad_b_i[2])))
      else $error("oscillator pin misrouted");
   gpi_gate_a: assert property (@(posedge i_ref_clk) disable iff (!rst_n_q)
      (i_gpi_en == 8'h00) |=> !o_general_pin_interrupt)
      else $error("interrupt with no enable");

endmodule

/* File: test/ppfm_board.sv */
// Board model: pull-ups and peer drivers resolving both port pads
`timescale 1ns/1ps
module ppfm_board (
   input  wire logic [7:0] i_a_o,
   input  wire logic [7:0] i_a_oe,
   input  wire logic [7:0] i_b_o,
   input  wire logic [7:0] i_b_oe,
   input  wire logic [7:0] i_a_drv,
   input  wire logic [7:0] i_a_val,
   input  wire logic [7:0] i_b_drv,
   input  wire logic [7:0] i_b_val,
   output logic      [7:0] o_a,
   output logic      [7:0] o_b
);
   // =============================================
   // Pad resolution
   // Released pins go to the pull-up level, never keep the last value
   always_comb begin
      for (int k = 0; k < 8; k++) begin
         o_a[k] = i_a_oe[k] ? i_a_o[k] : (i_a_drv[k] ? i_a_val[k] : 1'b1);
         o_b[k] = i_b_oe[k] ? i_b_o[k] : (i_b_drv[k] ? i_b_val[k] : 1'b1);
      end
   end
endmodule

/* File: test/port_pin_function_mux_test.sv */
// Self-checking bench for the port pin function multiplexer
`timescale 1ns/1ps
module port_pin_function_mux_test;
   logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_reset_fuse, i_on_chip_debug, i_rc_osc_sel, i_spi_en, i_spi_master;
   logic i_spi_mosi, i_spi_miso, i_spi_sck, i_t0_pwm_en, i_t0_pwm, i_t1_pwm_en, i_t1_pwm, i_dbg_data_oe;
   logic i_dbg_data_o, i_latch_wr_a, i_latch_wr_b;
   logic [7:0]  i_latch_a, i_latch_b, i_gpi_en, i_gpi_level, i_gpi_pol, i_pad_a_i, i_pad_b_i, a_drv, a_val, b_drv, b_val;
   logic [15:0] i_mode_a, i_mode_b;
   logic [7:0]  o_pad_a_o, o_pad_a_oe, o_pad_b_o, o_pad_b_oe, o_port_a_in, o_port_b_in;
   logic o_ext_reset_n, o_debug_serial_clock, o_debug_serial_data, o_oscillator_input, o_spi_mosi_in;
   logic o_spi_miso_in, o_spi_sck_in, o_timer_zero_pin, o_timer_one_pin, o_uart_rxd, o_general_pin_interrupt;
   int   err_count = 0, compares = 0, cycles = 0;
   // =============================================
   // Clock, design and board
   always #25 i_ref_clk = ~i_ref_clk;
   ppfm_port_pin_function_mux #(.QUASI_KICK(2)) dut_u (
      .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_reset_fuse(i_reset_fuse), .i_on_chip_debug(i_on_chip_debug),
      .i_rc_osc_sel(i_rc_osc_sel), .i_spi_en(i_spi_en), .i_spi_master(i_spi_master), .i_spi_mosi(i_spi_mosi),
      .i_spi_miso(i_spi_miso), .i_spi_sck(i_spi_sck), .i_t0_pwm_en(i_t0_pwm_en), .i_t0_pwm(i_t0_pwm),
      .i_t1_pwm_en(i_t1_pwm_en), .i_t1_pwm(i_t1_pwm), .i_dbg_data_oe(i_dbg_data_oe), .i_dbg_data_o(i_dbg_data_o),
      .i_latch_wr_a(i_latch_wr_a), .i_latch_a(i_latch_a), .i_latch_wr_b(i_latch_wr_b), .i_latch_b(i_latch_b),
      .i_mode_a(i_mode_a), .i_mode_b(i_mode_b), .i_gpi_en(i_gpi_en), .i_gpi_level(i_gpi_level),
      .i_gpi_pol(i_gpi_pol), .i_pad_a_i(i_pad_a_i), .i_pad_b_i(i_pad_b_i), .o_pad_a_o(o_pad_a_o),
      .o_pad_a_oe(o_pad_a_oe), .o_pad_b_o(o_pad_b_o), .o_pad_b_oe(o_pad_b_oe), .o_port_a_in(o_port_a_in),
      .o_port_b_in(o_port_b_in), .o_ext_reset_n(o_ext_reset_n), .o_debug_serial_clock(o_debug_serial_clock),
      .o_debug_serial_data(o_debug_serial_data), .o_oscillator_input(o_oscillator_input),
      .o_spi_mosi_in(o_spi_mosi_in), .o_spi_miso_in(o_spi_miso_in), .o_spi_sck_in(o_spi_sck_in),
      .o_timer_zero_pin(o_timer_zero_pin), .o_timer_one_pin(o_timer_one_pin), .o_uart_rxd(o_uart_rxd),
      .o_general_pin_interrupt(o_general_pin_interrupt));
   ppfm_board board_u (.i_a_o(o_pad_a_o), .i_a_oe(o_pad_a_oe), .i_b_o(o_pad_b_o), .i_b_oe(o_pad_b_oe),
      .i_a_drv(a_drv), .i_a_val(a_val), .i_b_drv(b_drv), .i_b_val(b_val), .o_a(i_pad_a_i), .o_b(i_pad_b_i));
   // =============================================
   // Tasks
   task automatic step(input int n);
      repeat (n) @(negedge i_ref_clk);
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask
   // One-cycle strobe; pads follow one edge after the write edge
   task automatic wr(input logic port_b, input logic [7:0] d);
      if (port_b) {i_latch_wr_b, i_latch_b} = {1'b1, d};
      else {i_latch_wr_a, i_latch_a} = {1'b1, d};
      step(1);
      {i_latch_wr_a, i_latch_wr_b} = 2'h0;
      step(3);
   endtask
   task automatic test_done;
      $display("errors=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Hang guard, far above the roughly one hundred cycles the tests need
   always @(posedge i_ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         test_done();
      end
   end
   // =============================================
   // Scenarios
   initial begin
      {i_reset_fuse, i_on_chip_debug, i_spi_en, i_spi_master, i_spi_mosi, i_spi_miso, i_spi_sck} = 7'h00;
      {i_t0_pwm_en, i_t0_pwm, i_t1_pwm_en, i_t1_pwm, i_dbg_data_oe, i_dbg_data_o} = 6'h00;
      {i_latch_wr_a, i_latch_wr_b, i_latch_a, i_latch_b, i_gpi_en, i_gpi_level, i_gpi_pol} = 42'h0;
      {a_drv, a_val, b_drv, b_val, i_mode_a, i_mode_b} = 64'h0;
      i_rc_osc_sel = 1'b1;
      repeat (6) @(negedge i_ref_clk);
      i_arst_n = 1'b1;
      step(4);
      chk1(o_ext_reset_n, 1'b1);
      chk8(o_pad_a_oe, 8'h00);
      i_mode_a = {8{ppfm_pkg::PPFM_PUSH}};
      i_mode_b = {8{ppfm_pkg::PPFM_PUSH}};
      wr(1'b0, 8'h00);
      wr(1'b1, 8'hA5);
      chk8(o_pad_a_o, 8'h00);
      chk8(o_pad_a_oe, 8'hFF);
      chk8(o_pad_b_o, 8'hA5);
      chk8(o_port_b_in, 8'hA5);
      i_mode_a = {8{ppfm_pkg::PPFM_OPEN}};
      wr(1'b0, 8'h0F);
      chk8(o_pad_a_oe, 8'hF0);
      chk8(o_pad_a_o & 8'hF0, 8'h00);
      chk8(o_port_a_in, 8'h0F);
      i_mode_a = {8{ppfm_pkg::PPFM_INPUT}};
      {a_drv, a_val} = 16'hFF5A;
      step(2);
      chk8(o_pad_a_oe, 8'h00);
      chk8(o_port_a_in, 8'h5A);
      a_drv = 8'h00;
      i_mode_a = {8{ppfm_pkg::PPFM_QUASI}};
      wr(1'b0, 8'h00);
      chk8(o_pad_a_oe, 8'hFF);
      wr(1'b0, 8'hFF);
      chk8(o_pad_a_oe & o_pad_a_o, 8'hFF);
      step(6);
      chk8(o_pad_a_oe, 8'h00);
      chk8(o_port_a_in, 8'hFF);
      i_mode_a = {8{ppfm_pkg::PPFM_INPUT}};
      {a_drv, i_gpi_level, i_gpi_pol} = 24'hFFFF00;
      for (int k = 0; k < 8; k++) begin
         a_val = ~(8'h01 << k);
         i_gpi_en = ~(8'h01 << k);
         step(2);
         chk1(o_general_pin_interrupt, 1'b0);
         i_gpi_en = 8'h01 << k;
         step(2);
         chk1(o_general_pin_interrupt, 1'b1);
      end
      {i_gpi_level, i_gpi_pol, i_gpi_en} = 24'h00FF01;
      step(2);
      chk1(o_general_pin_interrupt, 1'b0);
      a_val = 8'h7E;
      step(2);
      chk1(o_general_pin_interrupt, 1'b0);
      a_val = 8'h7F;
      step(1);
      chk1(o_general_pin_interrupt, 1'b1);
      step(1);
      chk1(o_general_pin_interrupt, 1'b0);
      {i_gpi_en, a_val} = 16'h00F7;
      i_mode_a = {8{ppfm_pkg::PPFM_PUSH}};
      i_reset_fuse = 1'b1;
      step(2);
      chk1(o_ext_reset_n, 1'b0);
      chk8(o_pad_a_oe, 8'hF7);
      i_reset_fuse = 1'b0;
      step(2);
      chk1(o_ext_reset_n, 1'b1);
      chk8(o_pad_a_oe, 8'hFF);
      {i_on_chip_debug, a_val} = 9'h108;
      step(2);
      chk1(o_debug_serial_clock, 1'b1);
      chk8(o_pad_a_oe, 8'hF7);
      {b_drv, b_val} = 16'hFFFB;
      step(2);
      chk1(o_debug_serial_data, 1'b0);
      chk1(o_pad_b_oe[2], 1'b0);
      {i_dbg_data_oe, i_dbg_data_o} = 2'h3;
      step(2);
      chk8(o_pad_b_oe & o_pad_b_o & 8'h04, 8'h04);
      {i_on_chip_debug, i_rc_osc_sel, i_dbg_data_oe} = 3'h0;
      step(2);
      chk1(o_oscillator_input, 1'b0);
      b_val = 8'hFF;
      step(2);
      chk1(o_oscillator_input, 1'b1);
      chk1(o_pad_b_oe[2], 1'b0);
      i_rc_osc_sel = 1'b1;
      step(2);
      chk1(o_oscillator_input, 1'b0);
      chk1(o_pad_b_oe[2], 1'b1);
      {a_drv, a_val, i_spi_en, i_spi_mosi, i_spi_miso, i_spi_sck} = 20'hFF00F;
      for (int m = 1; m >= 0; m--) begin
         i_spi_master = m[0];
         step(2);
         chk8(o_pad_a_oe & 8'hE0, m ? 8'hA0 : 8'h40);
         chk8({o_spi_sck_in, o_spi_miso_in, o_spi_mosi_in, 5'h00}, m ? 8'hA0 : 8'h40);
      end
      {i_spi_en, b_val} = 9'h000;
      i_mode_b = {8{ppfm_pkg::PPFM_INPUT}};
      {i_t0_pwm_en, i_t0_pwm, i_t1_pwm_en, i_t1_pwm} = 4'hF;
      step(2);
      chk8(o_pad_b_oe & o_pad_b_o, 8'h30);
      {i_t0_pwm_en, i_t1_pwm_en, b_val} = 10'h011;
      step(2);
      chk8(o_pad_b_oe, 8'h00);
      chk8({o_timer_one_pin, o_timer_zero_pin, o_uart_rxd}, 8'h03);
      b_val = 8'h00;
      step(2);
      chk1(o_uart_rxd, 1'b0);
      test_done();
   end
endmodule
